// ==== bench/sic_switch_model.sv ====
// Switch and comparator model facing the polled input currents.
`timescale 1ns/10ps
module sic_switch_model (
    input wire logic clk,
    input wire logic [23:0] closed,
    input wire logic [23:0] source_on,
    input wire logic [9:0] sink_on,
    output logic comp_out
);
    initial comp_out = 1'b0;

    // A closed switch to ground pulls a sourced pin low; a closed switch to
    // battery lifts a sunk pin high. With no current the pin floats, so the
    // output toggles to expose any sample taken outside the settle window.
    always @(posedge clk) begin
        if (|source_on) begin
            comp_out <= ~|(source_on & closed);
        end else if (|sink_on) begin
            comp_out <= |(sink_on & closed[9:0]);
        end else begin
            comp_out <= ~comp_out;
        end
    end
endmodule : sic_switch_model

// ==== bench/tb_sic_core.sv ====
// Self-checking bench for supply handling and input configuration.
`timescale 1ns/10ps
`include "sic_params.svh"
module tb_sic_core;
    import sic_pkg::*;
    localparam logic [23:0] CLOSED = 24'h5A_C3A5;
    localparam logic [23:0] EN = 24'hBF_7FFE;
    // Input 1 is a sink with its switch open, so both sink states are seen
    localparam logic [9:0] SINK = 10'h2A6;
    localparam logic [11:0] LVL = 12'hE4B;
    logic clk, reset, rise, fall, cs_n, rd, wr, comp;
    logic ev, pend, ovf, sce, live, run;
    logic [3:0] addr;
    logic [23:0] wdata, closed, st, en, src;
    logic [9:0] snk_sel, snk;
    logic [11:0] lvl;
    logic [7:0] poll;
    logic [4:0] ch;
    sic_level_t lsel;
    sic_wett_t wsel;
    int miscompares, compares;

    // Small settle count keeps each polling cycle a few hundred clocks
    sic_core #(.SETTLE_CYC(2)) sic_core_i (.clk(clk), .reset(reset),
        .vs_above_rise(rise), .vs_above_fall(fall), .cs_n(cs_n),
        .comp_out(comp), .event_reg_read(rd), .cfg_wr(wr), .cfg_addr(addr),
        .cfg_wdata(wdata), .event_drive(ev), .spi_event_pending_flag(pend),
        .supply_high_event_flag(ovf), .switch_change_event(sce),
        .supply_high_live_status(live), .switch_status(st), .run_bit(run),
        .sink_select(snk_sel), .input_enable(en),
        .comparator_level_select(lvl), .poll_timing_config_register(poll),
        .source_on(src), .sink_on(snk), .poll_channel(ch), .level_sel(lsel),
        .wetting_sel(wsel));
    sic_switch_model sic_switch_model_i (.clk(clk), .closed(closed),
        .source_on(src), .sink_on(snk), .comp_out(comp));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [23:0] exp,
                       input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic int fidx(int c);
        if (c < 4) return c / 2;
        if (c < 6) return c - 2;
        if (c < 10) return (c + 2) / 2;
        if (c < 12) return c - 4;
        if (c < 22) return (c + 4) / 2;
        return c - 9;
    endfunction : fidx

    // Whenever a current is on, it must belong to the polled input alone
    always @(negedge clk) begin
        if (!reset && (|src || |snk)) begin
            chk("current_in_ov", 24'h0, {23'h0, live});
            chk("channel_enabled", 24'h1, {23'h0, en[ch]});
            chk("source_on", (ch >= 10 || !snk_sel[ch]) ? 24'h1 << ch : 24'h0,
                src);
            chk("sink_on", (ch < 10 && snk_sel[ch]) ? 24'h1 << ch : 24'h0,
                {14'h0, snk});
            chk("level_sel", {22'h0, lvl[2*(ch/4)+:2]},
                {22'h0, lsel});
            chk("wetting_sel", 24'(fidx(ch) % 6), {21'h0, wsel});
        end
    end

    task automatic cfg(input logic [3:0] a, input logic [23:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : cfg

    task automatic frame(input logic read);
        @(posedge clk);
        cs_n <= 1'b0;
        rd <= read;
        @(posedge clk);
        rd <= 1'b0;
        repeat (3) @(posedge clk);
        cs_n <= 1'b1;
        repeat (5) @(negedge clk);
    endtask : frame

    task automatic supply(input logic r, input logic f);
        @(posedge clk);
        rise <= r;
        fall <= f;
        repeat (5) @(negedge clk);
    endtask : supply

    task automatic wait_ch(input logic [4:0] v);
        int n;
        n = 0;
        while (ch !== v && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk("poll_wait", 24'h1, {23'h0, n < 3000});
    endtask : wait_ch

    task automatic t_reset;
        @(negedge clk);
        chk("input_enable", 24'h0, en);
        chk("sink_select", 24'h0, {14'h0, snk_sel});
        chk("wetting_sel", 24'h0, {21'h0, wsel});
        $display("test reset done");
    endtask : t_reset

    task automatic t_config;
        // Settings go in while monitoring is stopped; with run set the enable write is refused and poll timing is taken
        cfg(`SIC_ADDR_SINK, {14'h0, SINK});
        cfg(`SIC_ADDR_ENABLE, EN);
        cfg(`SIC_ADDR_LEVEL, {12'h0, LVL});
        cfg(`SIC_ADDR_POLL, 24'h1);
        for (int f = 0; f < 15; f++)
            cfg(`SIC_ADDR_WETT, 24'((f % 6) * 16 + f));
        cfg(`SIC_ADDR_WETT, 24'h63);
        cfg(`SIC_ADDR_CONFIG, 24'h1);
        cfg(`SIC_ADDR_ENABLE, 24'h0);
        cfg(`SIC_ADDR_POLL, 24'h3);
        @(negedge clk);
        chk("sink_select", {14'h0, SINK}, {14'h0, snk_sel});
        chk("input_enable", EN, en);
        chk("level_select", {12'h0, LVL}, {12'h0, lvl});
        chk("poll_timing", 24'h3, {16'h0, poll});
        chk("run_bit", 24'h1, {23'h0, run});
        $display("test config done");
    endtask : t_config

    task automatic t_poll;
        wait_ch(5'd24);
        @(negedge clk);
        chk("switch_status", CLOSED & EN, st);
        // Clear the first-cycle event so the entry check sees a fresh one
        frame(1'b1);
        chk("event_idle", 24'h0, {23'h0, ev});
        $display("test poll done");
    endtask : t_poll

    task automatic t_ov;
        supply(1'b1, 1'b1);
        chk("event_drive", 24'h1, {23'h0, ev});
        chk("ov_flag", 24'h1, {23'h0, ovf});
        chk("ov_live", 24'h1, {23'h0, live});
        chk("pending", 24'h1, {23'h0, pend});
        closed = ~CLOSED;
        repeat (300) @(negedge clk);
        chk("status_held", CLOSED & EN, st);
        chk("enable_held", EN, en);
        frame(1'b0);
        chk("ov_flag_kept", 24'h1, {23'h0, ovf});
        chk("event_kept", 24'h1, {23'h0, ev});
        frame(1'b1);
        chk("ov_flag_clr", 24'h0, {23'h0, ovf});
        chk("event_clr", 24'h0, {23'h0, ev});
        chk("pending_clr", 24'h0, {23'h0, pend});
        supply(1'b0, 1'b1);
        repeat (20) @(negedge clk);
        chk("ov_live_hold", 24'h1, {23'h0, live});
        chk("no_new_event", 24'h0, {23'h0, ev});
        closed = CLOSED;
        supply(1'b0, 1'b0);
        chk("event_exit", 24'h1, {23'h0, ev});
        chk("ov_flag_exit", 24'h1, {23'h0, ovf});
        chk("ov_live_exit", 24'h0, {23'h0, live});
        $display("test over-voltage done");
    endtask : t_ov

    task automatic t_recover;
        int n;
        n = 0;
        while (!(|src || |snk) && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("first_channel", 24'h1, {19'h0, ch});
        frame(1'b1);
        chk("sce_clr", 24'h0, {23'h0, sce});
        wait_ch(5'd24);
        @(negedge clk);
        chk("sce_first_cycle", 24'h1, {23'h0, sce});
        chk("status_after", CLOSED & EN, st);
        frame(1'b1);
        wait_ch(5'd0);
        wait_ch(5'd24);
        @(negedge clk);
        chk("sce_baseline", 24'h0, {23'h0, sce});
        $display("test recovery done");
    endtask : t_recover

    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // Whole run is about a thousand clocks; this span cuts a hang short
    initial begin
        #(25 * 20000);
        miscompares++;
        tally_and_finish;
    end

    initial begin
        reset = 1'b1;
        rise = 1'b0;
        fall = 1'b0;
        cs_n = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdata = 24'h0;
        closed = CLOSED;
        miscompares = 0;
        compares = 0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_config;
        t_poll;
        t_ov;
        t_recover;
        tally_and_finish;
    end
endmodule : tb_sic_core

// ==== src/sic_core.sv ====
// Over-voltage handling, input configuration and switch polling.
`timescale 1ns/10ps
`include "sic_params.svh"

// Operation
// R1 - Over-voltage: all currents off, monitoring halted
// R2 - Entry: event line low, flag, live status
// R3 - Pending event shows in every SPI status
// R4 - CS rise clears flags only if read
// R5 - Over-voltage keeps registers and access intact
// R6 - Hysteresis hold; no repeat event while persisting
// R7 - Exit: event line low, flag, live clear
// R8 - Resume from lowest enabled input after recovery
// R9 - First cycle after recovery: event, new baseline
// R10 - Controller stops run before configuration changes
// R11 - Report open or closed for 24 inputs
// R12 - Wetting current shared by pairs or single
// R13 - Inputs 10 to 23 source only
// R14 - Sink select bit: 1 sink, 0 source
// R15 - Disabled input: currents off, not monitored
// R16 - Input enables reset to all disabled
// R17 - One threshold per group of four inputs
// R18 - Threshold choices 2, 2.7, 3, 4 volts
// R19 - Closed state from comparator and polarity
// R20 - Run set locks configuration except run, poll
// R21 - Six wetting currents, reset to 0 mA
module sic_core #(
    parameter int SETTLE_CYC = `SIC_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic vs_above_rise,
    input wire logic vs_above_fall,
    input wire logic cs_n,
    input wire logic comp_out,
    input wire logic event_reg_read,
    input wire logic cfg_wr,
    input wire logic [3:0] cfg_addr,
    input wire logic [23:0] cfg_wdata,
    output logic event_drive,
    output logic spi_event_pending_flag,
    output logic supply_high_event_flag,
    output logic switch_change_event,
    output logic supply_high_live_status,
    output logic [23:0] switch_status,
    output logic run_bit,
    output logic [9:0] sink_select,
    output logic [23:0] input_enable,
    output logic [11:0] comparator_level_select,
    output logic [7:0] poll_timing_config_register,
    output logic [23:0] source_on,
    output logic [9:0] sink_on,
    output logic [4:0] poll_channel,
    output sic_pkg::sic_level_t level_sel,
    output sic_pkg::sic_wett_t wetting_sel
);
    import sic_pkg::*;

    if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_chk
        $error("SETTLE_CYC out of range");
    end

    logic rise_s, fall_s, cs_s, comp_s, cs_prev_q;
    logic ov_q, read_seen_q, first_cycle_q;
    logic [2:0] wc_q [`SIC_NUM_WC];
    logic [23:0] scan_q, base_q;
    logic [7:0] units_q;
    logic [15:0] div_q;
    sic_state_t state_q, state_d;
    logic [4:0] ch_d;

    // Chip select idles high, so its stages reset high: no false edge
    sic_sync2 #(.WIDTH(4), .RST_VAL(4'b0010)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({vs_above_rise, vs_above_fall, cs_n, comp_out}),
        .sync_out({rise_s, fall_s, cs_s, comp_s})
    );

    // Supply window decode with hysteresis
    wire ov_enter = !ov_q && rise_s; // R1
    wire ov_leave = ov_q && !fall_s; // R6
    wire cs_rise = cs_s && !cs_prev_q;
    wire clr_evt = cs_rise && (read_seen_q || event_reg_read); // R4
    wire end_cycle = (state_q == SIC_ST_IDLE) && (ch_d == 5'h00)
        && (poll_channel == `SIC_CH_END);
    wire [23:0] scan_fin = scan_q;
    wire ssc_set = end_cycle && (first_cycle_q || scan_fin != base_q); // R9
    wire sh_set = ov_enter || ov_leave; // R2 R7
    wire sh_d = sh_set || (supply_high_event_flag && !clr_evt);
    wire ssc_d = ssc_set || (switch_change_event && !clr_evt);

    // Configuration writes; run bit set locks all but run and poll timing
    wire locked = run_bit; // R20
    wire wr_sink = cfg_wr && !locked && cfg_addr == `SIC_ADDR_SINK;
    wire wr_en = cfg_wr && !locked && cfg_addr == `SIC_ADDR_ENABLE;
    wire wr_lvl = cfg_wr && !locked && cfg_addr == `SIC_ADDR_LEVEL;
    wire wr_wc = cfg_wr && !locked && cfg_addr == `SIC_ADDR_WETT;
    wire wr_cfg = cfg_wr && cfg_addr == `SIC_ADDR_CONFIG;
    wire wr_poll = cfg_wr && cfg_addr == `SIC_ADDR_POLL;
    wire [3:0] wc_idx = cfg_wdata[`SIC_WETT_IDX_LSB +: 4];
    wire [2:0] wc_code = cfg_wdata[`SIC_WETT_CODE_LSB +: 3];
    wire wc_ok = (wc_idx < 4'd15) && (wc_code <= `SIC_WETT_MAX); // R21

    always_ff @(posedge clk) begin
        if (reset) begin
            run_bit <= 1'b0;
            sink_select <= `SIC_RST_SINK; // R14
            input_enable <= `SIC_RST_ENABLE; // R16
            comparator_level_select <= `SIC_RST_LEVEL;
            poll_timing_config_register <= `SIC_RST_POLL;
        end else begin
            if (wr_cfg) run_bit <= cfg_wdata[`SIC_RUN_BIT];
            if (wr_sink) sink_select <= cfg_wdata[9:0]; // R14
            if (wr_en) input_enable <= cfg_wdata; // R15
            if (wr_lvl) comparator_level_select <= cfg_wdata[11:0]; // R17
            if (wr_poll) poll_timing_config_register <= cfg_wdata[7:0];
        end
    end

    // One wetting field per pair or single input, each resets to 0 mA
    for (genvar g = 0; g < `SIC_NUM_WC; g++) begin : g_wc
        always_ff @(posedge clk) begin
            if (reset) wc_q[g] <= SIC_WC_0MA; // R21
            else if (wr_wc && wc_ok && wc_idx == 4'(g)) wc_q[g] <= wc_code;
        end
    end

    // Map an input to its wetting field
    function automatic logic [3:0] wc_field(input logic [4:0] ch);
        case (ch) // R12
            5'd0, 5'd1: wc_field = 4'd0;
            5'd2, 5'd3: wc_field = 4'd1;
            5'd4: wc_field = 4'd2;
            5'd5: wc_field = 4'd3;
            5'd6, 5'd7: wc_field = 4'd4;
            5'd8, 5'd9: wc_field = 4'd5;
            5'd10: wc_field = 4'd6;
            5'd11: wc_field = 4'd7;
            5'd12, 5'd13: wc_field = 4'd8;
            5'd14, 5'd15: wc_field = 4'd9;
            5'd16, 5'd17: wc_field = 4'd10;
            5'd18, 5'd19: wc_field = 4'd11;
            5'd20, 5'd21: wc_field = 4'd12;
            5'd22: wc_field = 4'd13;
            default: wc_field = 4'd14;
        endcase
    endfunction : wc_field

    // Settle divider: one enable pulse every SETTLE_CYC cycles
    wire tick = (div_q == 16'(SETTLE_CYC - 1));
    always_ff @(posedge clk) begin
        if (reset || state_q != SIC_ST_SETTLE) div_q <= 16'h0000;
        else div_q <= tick ? 16'h0000 : div_q + 16'h0001;
    end

    // Poll sequencer; halts on over-voltage or cleared run bit
    wire halt = !run_bit || ov_q || ov_enter; // R1 R5
    wire [23:0] en_ext = input_enable;
    wire cur_en = (poll_channel < `SIC_CH_END) && en_ext[poll_channel];
    always_comb begin
        state_d = state_q;
        ch_d = poll_channel;
        case (state_q)
            SIC_ST_HALT: begin
                ch_d = 5'h00; // R8
                if (!halt) state_d = SIC_ST_IDLE;
            end
            SIC_ST_IDLE: begin
                if (poll_channel == `SIC_CH_END) ch_d = 5'h00;
                else if (cur_en) state_d = SIC_ST_SETTLE; // R15
                else ch_d = poll_channel + 5'h01;
            end
            SIC_ST_SETTLE: begin
                // Compare is a bound: a smaller poll write mid-settle ends it
                if (tick && units_q >= poll_timing_config_register)
                    state_d = SIC_ST_SAMPLE;
            end
            SIC_ST_SAMPLE: begin
                state_d = SIC_ST_IDLE;
                ch_d = poll_channel + 5'h01;
            end
            default: state_d = SIC_ST_HALT;
        endcase
        if (halt) begin
            state_d = SIC_ST_HALT;
            ch_d = 5'h00;
        end
    end

    // Closed when level and polarity agree: source low, sink high
    wire [23:0] sink_ext = {14'h0000, sink_select}; // R13
    wire cur_sink = sink_ext[poll_channel]; // R14
    wire closed = cur_sink ? comp_s : !comp_s; // R19
    wire drive_d = (state_d == SIC_ST_SETTLE) || (state_d == SIC_ST_SAMPLE);
    wire [23:0] onehot_d = drive_d ? (24'h00_0001 << ch_d) : 24'h00_0000;
    wire [23:0] snk_d = onehot_d & sink_ext; // R13 R14
    wire [4:0] ch_sel = (ch_d < `SIC_CH_END) ? ch_d : 5'h00;
    wire [11:0] lvl_vec = comparator_level_select; // R17 R18

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= SIC_ST_HALT;
            poll_channel <= 5'h00;
            units_q <= 8'h00;
            scan_q <= 24'h00_0000;
            source_on <= 24'h00_0000;
            sink_on <= 10'h000;
            level_sel <= SIC_LVL_2V0;
            wetting_sel <= SIC_WC_0MA;
        end else begin
            state_q <= state_d;
            poll_channel <= ch_d;
            if (state_q != SIC_ST_SETTLE) units_q <= 8'h00;
            else if (tick) units_q <= units_q + 8'h01;
            if (state_q == SIC_ST_SAMPLE) scan_q[poll_channel] <= closed;
            else if (state_q == SIC_ST_IDLE && !cur_en && !halt
                && poll_channel < `SIC_CH_END)
                scan_q[poll_channel] <= 1'b0; // R15
            source_on <= onehot_d & ~snk_d; // R1 R15
            sink_on <= snk_d[9:0];
            level_sel <= sic_level_t'(lvl_vec[{ch_sel[4:2], 1'b0} +: 2]);
            wetting_sel <= sic_wett_t'(wc_q[wc_field(ch_sel)]); // R12 R21
        end
    end

    // Supply state, event flags and event line; a set wins over a clear
    always_ff @(posedge clk) begin
        if (reset) begin
            ov_q <= 1'b0;
            cs_prev_q <= 1'b1;
            read_seen_q <= 1'b0;
            first_cycle_q <= 1'b0;
            base_q <= 24'h00_0000;
            switch_status <= 24'h00_0000;
            supply_high_event_flag <= 1'b0;
            switch_change_event <= 1'b0;
            supply_high_live_status <= 1'b0;
            spi_event_pending_flag <= 1'b0;
            event_drive <= 1'b0;
        end else begin
            cs_prev_q <= cs_s;
            if (ov_enter) ov_q <= 1'b1;
            else if (ov_leave) ov_q <= 1'b0;
            supply_high_live_status <= (ov_q || ov_enter) && !ov_leave;
            if (cs_rise) read_seen_q <= 1'b0;
            else if (event_reg_read) read_seen_q <= 1'b1;
            if (ov_leave) first_cycle_q <= 1'b1; // R9
            else if (end_cycle) first_cycle_q <= 1'b0;
            if (end_cycle) begin
                base_q <= scan_fin; // R9
                switch_status <= scan_fin; // R11
            end
            supply_high_event_flag <= sh_d; // R2 R7
            switch_change_event <= ssc_d;
            spi_event_pending_flag <= sh_d || ssc_d; // R3
            if (sh_set || ssc_set) event_drive <= 1'b1; // R2 R7
            else if (clr_evt) event_drive <= 1'b0; // R4
        end
    end

    // Checks
    chk_ov_currents_off: assert property ( // R1
        @(posedge clk) disable iff (reset)
        ov_q |-> (source_on == 24'h00_0000 && sink_on == 10'h000))
        else $error("current on during over-voltage");
    chk_ov_entry_flags: assert property ( // R2
        @(posedge clk) disable iff (reset)
        $rose(ov_q) |-> supply_high_event_flag && event_drive
        && supply_high_live_status)
        else $error("entry did not raise event");
    chk_pending_status: assert property ( // R3
        @(posedge clk) disable iff (reset)
        supply_high_event_flag |-> spi_event_pending_flag)
        else $error("pending flag missing");
    chk_clear_on_cs: assert property ( // R4
        @(posedge clk) disable iff (reset)
        clr_evt && !sh_set && !ssc_set |=> !event_drive
        && !supply_high_event_flag && !spi_event_pending_flag)
        else $error("flags not cleared on cs rise");
    chk_hold_no_clear: assert property ( // R4
        @(posedge clk) disable iff (reset)
        event_drive && !cs_rise |=> event_drive)
        else $error("event line released without cs rise");
    chk_ov_cfg_kept: assert property ( // R5
        @(posedge clk) disable iff (reset)
        ov_q && !cfg_wr |=> $stable(input_enable) && $stable(switch_status))
        else $error("register changed during over-voltage");
    chk_no_repeat: assert property ( // R6
        @(posedge clk) disable iff (reset)
        ov_q && $past(ov_q) |-> !$rose(event_drive))
        else $error("repeat event during over-voltage");
    chk_ov_exit_flags: assert property ( // R7
        @(posedge clk) disable iff (reset)
        $fell(ov_q) |-> supply_high_event_flag && event_drive
        && !supply_high_live_status)
        else $error("exit did not raise event");
    chk_resume_first: assert property ( // R8
        @(posedge clk) disable iff (reset)
        $fell(ov_q) && run_bit |=> poll_channel == 5'h00
        && state_q == SIC_ST_IDLE)
        else $error("polling not restarted from input 0");
    chk_disabled_off: assert property ( // R15
        @(posedge clk) disable iff (reset)
        (source_on & ~$past(input_enable)) == 24'h00_0000)
        else $error("disabled input driven");
    chk_locked_cfg: assert property ( // R20
        @(posedge clk) disable iff (reset)
        run_bit && cfg_wr && cfg_addr == `SIC_ADDR_ENABLE
        |=> $stable(input_enable))
        else $error("locked register written");
    cov_ov_enter: cover property (@(posedge clk) disable iff (reset)
        $rose(ov_q));
    cov_ov_exit_ssc: cover property (@(posedge clk) disable iff (reset)
        $fell(ov_q) ##[1:1000] $rose(switch_change_event));
    cov_clear: cover property (@(posedge clk) disable iff (reset)
        $fell(event_drive));
endmodule : sic_core

// ==== src/sic_params.svh ====
// Offsets, field positions, reset values and timing counts of the block.
`ifndef SIC_PARAMS_SVH
`define SIC_PARAMS_SVH

`define SIC_NUM_IN 24
`define SIC_NUM_SINK 10
`define SIC_NUM_WC 15
`define SIC_CH_W 5
`define SIC_CH_END 5'h18
`define SIC_CH_SINK_END 5'h0A
`define SIC_ADDR_SINK 4'h0
`define SIC_ADDR_ENABLE 4'h1
`define SIC_ADDR_LEVEL 4'h2
`define SIC_ADDR_WETT 4'h3
`define SIC_ADDR_CONFIG 4'h4
`define SIC_ADDR_POLL 4'h5
`define SIC_WETT_IDX_LSB 0
`define SIC_WETT_CODE_LSB 4
`define SIC_RUN_BIT 0
`define SIC_WETT_MAX 3'h5
`define SIC_RST_SINK 10'h000
`define SIC_RST_ENABLE 24'h00_0000
`define SIC_RST_LEVEL 12'h000
`define SIC_RST_POLL 8'h00
`define SIC_CLK_NS 25
`define SIC_SETTLE_NS 1000
`define SIC_SETTLE_CYC ((`SIC_SETTLE_NS + `SIC_CLK_NS - 1) / `SIC_CLK_NS)

`endif

// ==== src/sic_pkg.sv ====
// Types shared by the switch input configuration block.
package sic_pkg;
    typedef enum logic [1:0] {
        SIC_LVL_2V0 = 2'b00,
        SIC_LVL_2V7 = 2'b01,
        SIC_LVL_3V0 = 2'b10,
        SIC_LVL_4V0 = 2'b11
    } sic_level_t;
    typedef enum logic [2:0] {
        SIC_WC_0MA = 3'b000,
        SIC_WC_1MA = 3'b001,
        SIC_WC_2MA = 3'b010,
        SIC_WC_5MA = 3'b011,
        SIC_WC_10MA = 3'b100,
        SIC_WC_15MA = 3'b101
    } sic_wett_t;
    typedef enum logic [1:0] {
        SIC_ST_HALT = 2'b00,
        SIC_ST_IDLE = 2'b01,
        SIC_ST_SETTLE = 2'b10,
        SIC_ST_SAMPLE = 2'b11
    } sic_state_t;
endpackage : sic_pkg

// ==== src/sic_sync2.sv ====
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/10ps
module sic_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sic_sync2
